// File: bench/sss_regs_tb_top.sv
// Self-checking bench for the SPI slave semaphore register block
`timescale 1ns/100ps
module sss_regs_tb_top
    import sss_pkg::*;
;
    logic clk, rst, wr_en, rd_en, rd_pend;
    logic [11:0] addr;
    logic [31:0] wr_data, rd_data, d;
    logic sck, csn_n, mosi, miso_o, miso_oe_n, irq;
    logic [31:0] exp_q [$];
    logic [7:0] fill, ovr;
    logic [7:0] tx [2];
    logic [11:0] offs [4] = '{OFF_PSEL_MISO, OFF_RX_LIMIT, OFF_RX_LIST, OFF_OVR_FILL};
    logic [31:0] msks [4] = '{32'hFFFFFFFF, 32'h000000FF, 32'h00000007, 32'h000000FF};
    int errors, comparisons, cycles, seed;

    sss_regs #(.CNT_W(8), .BUF_AW(4)) dut_u (
        .clk(clk), .rst(rst), .addr(addr), .wr_en(wr_en), .wr_data(wr_data),
        .rd_en(rd_en), .rd_data(rd_data), .sck_i(sck), .csn_n_i(csn_n),
        .mosi_i(mosi), .miso_o(miso_o), .miso_oe_n(miso_oe_n), .irq(irq)
    );

    sss_spi_master master_u (
        .sck(sck), .csn_n(csn_n), .mosi(mosi), .miso(miso_o), .miso_oe_n(miso_oe_n)
    );

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic end_of_test;
        if (errors == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : end_of_test

    task automatic chk(input logic [31:0] got, input logic [31:0] e);
        comparisons++;
        if (got !== e) begin
            errors++;
            $display("unexpected at %0t: got %h wanted %h", $time, got, e);
        end
    endtask : chk

    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        @(posedge clk);
        addr <= a;
        wr_data <= v;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        exp_q.push_back(e);
        @(posedge clk);
        rd_en <= 1'b0;
    endtask : rd

    task automatic irq_is(input logic e);
        repeat (3) @(posedge clk);
        chk({31'h0, irq}, {31'h0, e});
    endtask : irq_is

    // Read data monitor and cycle ceiling
    always @(posedge clk) begin
        cycles++;
        if (cycles > 20000) begin
            errors++;
            end_of_test();
        end else begin
            if (rd_pend === 1'b1) chk(rd_data, exp_q.pop_front());
            rd_pend = rd_en;
        end
    end

    initial begin
        seed = 72484;
        rst = 1'b1;
        addr = '0;
        wr_en = 1'b0;
        wr_data = '0;
        rd_en = 1'b0;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        rd(OFF_OWNER, 32'h1);
        rd(OFF_ENABLE, 32'h0);
        rd(OFF_DONE_EV, 32'h0);
        rd(OFF_RXFULL_EV, 32'h0);
        rd(OFF_STATUS, 32'h0);
        rd(OFF_PSEL_SCK, PSEL_RST);
        rd(OFF_IGN_FILL, {24'h0, FILL_RST});
        rd(OFF_LOCK_REQ, 32'h0);
        wr(12'h7F0, 32'h0000FFFF);
        rd(12'h7F0, 32'h0);
        for (int i = 0; i < 4; i++) begin
            d = 32'($random(seed));
            wr(offs[i], d);
            rd(offs[i], d & msks[i]);
        end
        wr(OFF_ENABLE, 32'h1);
        wr(OFF_IRQ_SET, 32'h7);
        rd(OFF_IRQ_SET, 32'h7);
        wr(OFF_LOCK_REQ, 32'h1);
        rd(OFF_GRANT_EV, 32'h1);
        irq_is(1'b1);
        wr(OFF_IRQ_CLR, 32'h4);
        rd(OFF_IRQ_SET, 32'h3);
        irq_is(1'b0);
        rd(OFF_GRANT_EV, 32'h1);
        wr(OFF_GRANT_EV, 32'h0);
        rd(OFF_GRANT_EV, 32'h0);
        // Ignored frame while the CPU holds the lock
        fill = 8'($random(seed));
        wr(OFF_IGN_FILL, {24'h0, fill});
        master_u.tx_b[0] = 8'($random(seed));
        master_u.tx_b[1] = 8'($random(seed));
        master_u.frame(2);
        chk({24'h0, master_u.rx_b[0]}, {24'h0, fill});
        chk({24'h0, master_u.rx_b[1]}, {24'h0, fill});
        chk({31'h0, miso_oe_n}, 32'h1);
        rd(OFF_OWNER, 32'h1);
        rd(OFF_DONE_EV, 32'h0);
        wr(OFF_GIVEBACK, 32'h1);
        rd(OFF_OWNER, 32'h0);
        // Granted frame past both limits
        wr(OFF_RX_PTR, 32'h0);
        wr(OFF_TX_PTR, 32'h0);
        wr(OFF_RX_LIMIT, 32'h3);
        wr(OFF_TX_LIMIT, 32'h2);
        ovr = 8'($random(seed));
        wr(OFF_OVR_FILL, {24'h0, ovr});
        for (int i = 0; i < 2; i++) begin
            tx[i] = 8'($random(seed));
            wr(OFF_BUF_IDX, i);
            wr(OFF_BUF_DATA, {24'h0, tx[i]});
        end
        for (int i = 0; i < 4; i++) master_u.tx_b[i] = 8'($random(seed));
        master_u.frame(4);
        for (int i = 0; i < 4; i++) begin
            chk({24'h0, master_u.rx_b[i]}, {24'h0, (i < 2) ? tx[i] : ovr});
        end
        rd(OFF_OWNER, 32'h0);
        rd(OFF_DONE_EV, 32'h1);
        rd(OFF_RX_COUNT, 32'h3);
        rd(OFF_TX_COUNT, 32'h2);
        rd(OFF_STATUS, (32'h1 << ST_OVERREAD) | (32'h1 << ST_OVERFLOW));
        rd(OFF_RXFULL_EV, 32'h1);
        for (int i = 0; i < 3; i++) begin
            wr(OFF_BUF_IDX, i);
            rd(OFF_BUF_DATA, {24'h0, master_u.tx_b[i]});
        end
        irq_is(1'b1);
        wr(OFF_STATUS, 32'h3);
        rd(OFF_STATUS, 32'h0);
        wr(OFF_DONE_EV, 32'h0);
        wr(OFF_RXFULL_EV, 32'h0);
        irq_is(1'b0);
        // Shortcut hands the lock back to the CPU
        wr(OFF_EVENT_TASK_SHORTCUTS, 32'h1);
        fork
            master_u.frame(1);
            begin
                repeat (100) @(posedge clk);
                rd(OFF_OWNER, 32'h2);
            end
        join
        chk({24'h0, master_u.rx_b[0]}, {24'h0, tx[0]});
        rd(OFF_OWNER, 32'h1);
        rd(OFF_GRANT_EV, 32'h1);
        rd(OFF_RX_COUNT, 32'h1);
        rd(OFF_TX_COUNT, 32'h1);
        rd(OFF_STATUS, 32'h0);
        rd(OFF_DONE_EV, 32'h1);
        // Reset in mid-run returns the lock to the CPU
        repeat (2) @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rd(OFF_OWNER, 32'h1);
        rd(OFF_ENABLE, 32'h0);
        rd(OFF_DONE_EV, 32'h0);
        irq_is(1'b0);
        repeat (3) @(posedge clk);
        end_of_test();
    end
endmodule : sss_regs_tb_top

// File: bench/sss_spi_master.sv
// SPI master model that frames bytes towards the slave
`timescale 1ns/100ps
module sss_spi_master (
    // Serial pins
    output logic sck,
    output logic csn_n,
    output logic mosi,
    input wire logic miso,
    input wire logic miso_oe_n
);
    logic [7:0] tx_b [4];
    logic [7:0] rx_b [4];

    initial begin
        sck = 1'b0;
        csn_n = 1'b1;
        mosi = 1'b0;
    end

    // Mode 0: data set while clock low, sampled on rise; clock idles low
    task automatic frame(input int n);
        // Step off the caller's clock edge
        #1;
        csn_n = 1'b0;
        #250;
        for (int i = 0; i < n; i++) begin
            for (int b = 7; b >= 0; b--) begin
                mosi = tx_b[i][b];
                #62.5;
                sck = 1'b1;
                rx_b[i][b] = (miso_oe_n === 1'b0) ? miso : 1'bx;
                #62.5;
                sck = 1'b0;
            end
        end
        #250;
        csn_n = 1'b1;
        // Released line shows no stale value
        mosi = ~mosi;
        #500;
    endtask : frame
endmodule : sss_spi_master

// File: design/sss_pkg.sv
// Constants and types shared by the SPI slave semaphore register block
package sss_pkg;
    localparam int ADDR_W = 12;
    localparam logic [11:0] OFF_LOCK_REQ = 12'h024;
    localparam logic [11:0] OFF_GIVEBACK = 12'h028;
    localparam logic [11:0] OFF_DONE_EV = 12'h104;
    localparam logic [11:0] OFF_RXFULL_EV = 12'h110;
    localparam logic [11:0] OFF_GRANT_EV = 12'h128;
    localparam logic [11:0] OFF_EVENT_TASK_SHORTCUTS = 12'h200;
    localparam logic [11:0] OFF_IRQ_SET = 12'h304;
    localparam logic [11:0] OFF_IRQ_CLR = 12'h308;
    localparam logic [11:0] OFF_OWNER = 12'h400;
    localparam logic [11:0] OFF_STATUS = 12'h440;
    localparam logic [11:0] OFF_ENABLE = 12'h500;
    localparam logic [11:0] OFF_PSEL_SCK = 12'h508;
    localparam logic [11:0] OFF_PSEL_MISO = 12'h50C;
    localparam logic [11:0] OFF_PSEL_MOSI = 12'h510;
    localparam logic [11:0] OFF_CHIP_SELECT_PIN_SELECT = 12'h514;
    localparam logic [11:0] OFF_RX_PTR = 12'h534;
    localparam logic [11:0] OFF_RX_LIMIT = 12'h538;
    localparam logic [11:0] OFF_RX_COUNT = 12'h53C;
    localparam logic [11:0] OFF_RX_LIST = 12'h540;
    localparam logic [11:0] OFF_TX_PTR = 12'h544;
    localparam logic [11:0] OFF_TX_LIMIT = 12'h548;
    localparam logic [11:0] OFF_TX_COUNT = 12'h54C;
    localparam logic [11:0] OFF_TX_LIST = 12'h550;
    localparam logic [11:0] OFF_IGN_FILL = 12'h55C;
    localparam logic [11:0] OFF_OVR_FILL = 12'h5C0;
    localparam logic [11:0] OFF_BUF_IDX = 12'h580;
    localparam logic [11:0] OFF_BUF_DATA = 12'h584;
    // Event bit positions, shared by event, enable and irq logic
    localparam int EV_DONE = 0;
    localparam int EV_RXFULL = 1;
    localparam int EV_GRANT = 2;
    localparam int NUM_EV = 3;
    // Status bit positions
    localparam int ST_OVERREAD = 0;
    localparam int ST_OVERFLOW = 1;
    localparam int LIST_W = 3;
    localparam logic [31:0] PSEL_RST = 32'hFFFFFFFF;
    localparam logic [7:0] FILL_RST = 8'h00;
    localparam logic [2:0] PIN_SYNC_RST = 3'h2;
    typedef enum logic [1:0] {SEM_FREE, SEM_CPU, SEM_SPI} sss_sem_t;
endpackage : sss_pkg

// File: design/sss_regs.sv
// SPI slave with buffer semaphore, event flags and register port
// What this block does
// RULE_01 - Writing one to give-back hands the semaphore from CPU to free.
// RULE_02 - Receive-full flag reads one after the receive buffer fills.
// RULE_03 - Ignored transactions shift out the ignored-fill character.
// RULE_04 - Receive count shows bytes stored in the last granted transaction.
// RULE_05 - Transmit count shows bytes taken in the last granted transaction.
// RULE_06 - Receive limit caps bytes stored per granted transaction.
// RULE_07 - Transmit limit caps bytes taken per granted transaction.
// RULE_08 - Status register holds error bits from the latest transaction.
// RULE_09 - Shortcut hands the semaphore to CPU when a transaction ends.
// RULE_10 - End of granted transaction frees semaphore and raises done flag.
// RULE_11 - Chip-select fall takes semaphore, else transaction is ignored.
// RULE_12 - Lock request while CPU owns semaphore raises granted flag at once.
// RULE_13 - Bytes beyond receive limit are dropped and flag overflow.
// RULE_14 - Event flags stay set until software writes zero. Code takes receive-full and granted writes from bits 1 and 2, not bit 0.
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/100ps
module sss_regs
    import sss_pkg::*;
#(
    parameter int CNT_W = 8,
    parameter int BUF_AW = 4
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register port
    input wire logic [ADDR_W-1:0] addr,
    input wire logic wr_en,
    input wire logic [31:0] wr_data,
    input wire logic rd_en,
    output logic [31:0] rd_data,
    // Serial pins
    input wire logic sck_i,
    input wire logic csn_n_i,
    input wire logic mosi_i,
    output logic miso_o,
    output logic miso_oe_n,
    // Interrupt
    output logic irq
);
    localparam int DEPTH = 2 ** BUF_AW;

    logic [2:0] sync1_ff;
    logic [2:0] sync2_ff;
    logic sck_d_ff;
    logic csn_d_ff;
    sss_sem_t owner_ff;
    logic pend_ff;
    logic en_ff;
    logic event_task_shortcuts_ff;
    logic [NUM_EV-1:0] ev_ff;
    logic [NUM_EV-1:0] inten_ff;
    logic [1:0] st_ff;
    logic irq_ff;
    logic [31:0] psel_ff [4];
    logic [31:0] rx_ptr_ff;
    logic [31:0] tx_ptr_ff;
    logic [CNT_W-1:0] rx_lim_ff;
    logic [CNT_W-1:0] tx_lim_ff;
    logic [CNT_W-1:0] rx_count_ff;
    logic [CNT_W-1:0] tx_count_ff;
    logic [LIST_W-1:0] rx_list_ff;
    logic [LIST_W-1:0] tx_list_ff;
    logic [7:0] ign_fill_ff;
    logic [7:0] ovr_fill_ff;
    logic [BUF_AW-1:0] idx_ff;
    logic [7:0] rx_mem [DEPTH];
    logic [7:0] tx_mem [DEPTH];
    logic active_ff;
    logic granted_ff;
    logic oe_n_ff;
    logic [2:0] bit_ff;
    logic [7:0] rx_sh_ff;
    logic [7:0] tx_sh_ff;
    logic [CNT_W-1:0] rx_cnt_ff;
    logic [CNT_W-1:0] tx_cnt_ff;
    logic cur_take_ff;
    logic cur_ovr_ff;
    logic [31:0] rd_data_ff;
    logic [31:0] nxt_rd_data;
    logic [7:0] nxt_tx_byte;
    logic nxt_take;
    logic nxt_ovr;
    logic nxt_grant;
    logic [CNT_W-1:0] tx_base;

    function automatic logic wr_at(input logic [ADDR_W-1:0] off);
        return wr_en && (addr == off);
    endfunction : wr_at

    // Pin synchronisers, then edge detect on the second stage
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sync1_ff <= PIN_SYNC_RST;
            sync2_ff <= PIN_SYNC_RST;
            sck_d_ff <= 1'b0;
            csn_d_ff <= 1'b1;
        end else begin
            sync1_ff <= {mosi_i, csn_n_i, sck_i};
            sync2_ff <= sync1_ff;
            sck_d_ff <= sync2_ff[0];
            csn_d_ff <= sync2_ff[1];
        end
    end

    wire sck_rise = sync2_ff[0] && !sck_d_ff;
    wire sck_fall = !sync2_ff[0] && sck_d_ff;
    wire cs_fall = en_ff && !sync2_ff[1] && csn_d_ff;
    wire cs_rise = active_ff && sync2_ff[1];
    wire lock_req = en_ff && wr_at(OFF_LOCK_REQ) && wr_data[0];
    wire lock_give = en_ff && wr_at(OFF_GIVEBACK) && wr_data[0];
    // RULE_11 take on select fall
    wire spi_take = cs_fall && (owner_ff == SEM_FREE) && !lock_req;
    wire done = cs_rise && granted_ff;
    wire cpu_next = pend_ff || lock_req || event_task_shortcuts_ff;
    wire byte_done = active_ff && sck_rise && (bit_ff == 3'h7);
    wire [7:0] rx_byte = {rx_sh_ff[6:0], sync2_ff[2]};
    wire rx_room = rx_cnt_ff < rx_lim_ff;
    wire rx_store = byte_done && granted_ff && rx_room;
    wire rx_over = byte_done && granted_ff && !rx_room;
    wire rx_full = rx_store && ((rx_cnt_ff + 1'b1) == rx_lim_ff);
    wire load = cs_fall || (active_ff && sck_fall && (bit_ff == 3'h0));
    wire [BUF_AW-1:0] rx_idx = rx_ptr_ff[BUF_AW-1:0] + rx_cnt_ff[BUF_AW-1:0];
    wire [BUF_AW-1:0] tx_idx = tx_ptr_ff[BUF_AW-1:0] + tx_base[BUF_AW-1:0];
    wire grant_set = (lock_req && owner_ff != SEM_SPI) || (done && cpu_next);
    wire [NUM_EV-1:0] ev_set = {grant_set, rx_full, done};
    wire [NUM_EV-1:0] ev_wr = {wr_at(OFF_GRANT_EV), wr_at(OFF_RXFULL_EV),
        wr_at(OFF_DONE_EV)};

    // Semaphore owner; CPU holds it while disabled and right after enable
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            owner_ff <= SEM_CPU;
            pend_ff <= 1'b0;
        end else if (!en_ff) begin
            owner_ff <= SEM_CPU;
            pend_ff <= 1'b0;
        end else if (done) begin
            // RULE_10 free at end
            // RULE_09 shortcut to CPU
            owner_ff <= cpu_next ? SEM_CPU : SEM_FREE;
            pend_ff <= 1'b0;
        end else if (lock_req) begin
            // RULE_12 lock request
            if (owner_ff == SEM_SPI) begin
                pend_ff <= 1'b1;
            end else begin
                owner_ff <= SEM_CPU;
            end
        end else if (lock_give && owner_ff == SEM_CPU) begin
            // RULE_01 give back
            owner_ff <= SEM_FREE;
        end else if (spi_take) begin
            owner_ff <= SEM_SPI;
        end
    end

    // Sticky event flags, hardware set beats software clear
    generate
        for (genvar i = 0; i < NUM_EV; i++) begin : g_ev
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    ev_ff[i] <= 1'b0;
                end else begin
                    // RULE_14 write zero clears
                    ev_ff[i] <= ev_set[i] || (ev_wr[i] ? wr_data[i] : ev_ff[i]);
                end
            end
        end
    endgenerate

    // Interrupt enable set/clear and level output
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            inten_ff <= '0;
            irq_ff <= 1'b0;
        end else begin
            if (wr_at(OFF_IRQ_SET)) begin
                inten_ff <= inten_ff | wr_data[NUM_EV-1:0];
            end else if (wr_at(OFF_IRQ_CLR)) begin
                inten_ff <= inten_ff & ~wr_data[NUM_EV-1:0];
            end
            irq_ff <= |(ev_ff & inten_ff);
        end
    end

    // Status of latest transaction, write one to clear
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_ff <= '0;
        end else begin
            // RULE_08 error status
            // RULE_13 overflow flag
            st_ff[ST_OVERREAD] <= (byte_done && cur_ovr_ff) ||
                (st_ff[ST_OVERREAD] && !(wr_at(OFF_STATUS) && wr_data[ST_OVERREAD]));
            st_ff[ST_OVERFLOW] <= rx_over ||
                (st_ff[ST_OVERFLOW] && !(wr_at(OFF_STATUS) && wr_data[ST_OVERFLOW]));
        end
    end

    // Plain configuration registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            en_ff <= 1'b0;
            event_task_shortcuts_ff <= 1'b0;
            rx_ptr_ff <= '0;
            tx_ptr_ff <= '0;
            rx_lim_ff <= '0;
            tx_lim_ff <= '0;
            rx_list_ff <= '0;
            tx_list_ff <= '0;
            ign_fill_ff <= FILL_RST;
            ovr_fill_ff <= FILL_RST;
            idx_ff <= '0;
        end else if (wr_en) begin
            unique case (addr)
                OFF_ENABLE: en_ff <= wr_data[0];
                OFF_EVENT_TASK_SHORTCUTS: event_task_shortcuts_ff <= wr_data[0];
                OFF_RX_PTR: rx_ptr_ff <= wr_data;
                OFF_TX_PTR: tx_ptr_ff <= wr_data;
                OFF_RX_LIMIT: rx_lim_ff <= wr_data[CNT_W-1:0];
                OFF_TX_LIMIT: tx_lim_ff <= wr_data[CNT_W-1:0];
                OFF_RX_LIST: rx_list_ff <= wr_data[LIST_W-1:0];
                OFF_TX_LIST: tx_list_ff <= wr_data[LIST_W-1:0];
                OFF_IGN_FILL: ign_fill_ff <= wr_data[7:0];
                OFF_OVR_FILL: ovr_fill_ff <= wr_data[7:0];
                OFF_BUF_IDX: idx_ff <= wr_data[BUF_AW-1:0];
                default: ;
            endcase
        end
    end

    generate
        for (genvar p = 0; p < 4; p++) begin : g_psel
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    psel_ff[p] <= PSEL_RST;
                end else if (wr_at(OFF_PSEL_SCK + ADDR_W'(4 * p))) begin
                    psel_ff[p] <= wr_data;
                end
            end
        end
    endgenerate

    // Buffers: software fills transmit, SPI fills receive
    always_ff @(posedge clk) begin
        if (wr_at(OFF_BUF_DATA)) begin
            tx_mem[idx_ff] <= wr_data[7:0];
        end
    end

    always_ff @(posedge clk) begin
        if (rx_store) begin
            rx_mem[rx_idx] <= rx_byte;
        end
    end

    // Next transmit byte source
    always_comb begin
        nxt_grant = cs_fall ? spi_take : granted_ff;
        tx_base = cs_fall ? '0 : tx_cnt_ff;
        nxt_tx_byte = ign_fill_ff;
        nxt_take = 1'b0;
        nxt_ovr = 1'b0;
        if (nxt_grant) begin
            // RULE_07 transmit limit
            if (tx_base < tx_lim_ff) begin
                nxt_tx_byte = tx_mem[tx_idx];
                nxt_take = 1'b1;
            end else begin
                nxt_tx_byte = ovr_fill_ff;
                nxt_ovr = 1'b1;
            end
        end
    end

    // Transaction engine, mode 0: sample on rise, shift on fall
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            active_ff <= 1'b0;
            granted_ff <= 1'b0;
            oe_n_ff <= 1'b1;
            bit_ff <= '0;
            rx_sh_ff <= '0;
            tx_sh_ff <= '0;
            rx_cnt_ff <= '0;
            tx_cnt_ff <= '0;
            cur_take_ff <= 1'b0;
            cur_ovr_ff <= 1'b0;
        end else if (!en_ff || cs_rise) begin
            active_ff <= 1'b0;
            granted_ff <= 1'b0;
            oe_n_ff <= 1'b1;
        end else begin
            if (cs_fall) begin
                active_ff <= 1'b1;
                granted_ff <= spi_take;
                oe_n_ff <= 1'b0;
                bit_ff <= '0;
                rx_cnt_ff <= '0;
                tx_cnt_ff <= '0;
            end else if (active_ff && sck_rise) begin
                bit_ff <= bit_ff + 1'b1;
                rx_sh_ff <= rx_byte;
            end
            // RULE_06 receive limit
            if (rx_store) begin
                rx_cnt_ff <= rx_cnt_ff + 1'b1;
            end
            // RULE_05 count bytes sent
            if (byte_done && cur_take_ff) begin
                tx_cnt_ff <= tx_cnt_ff + 1'b1;
            end
            // Prefetched byte counts only once it is fully shifted out
            if (load) begin
                // RULE_03 ignored fill
                tx_sh_ff <= nxt_tx_byte;
                cur_take_ff <= nxt_take;
                cur_ovr_ff <= nxt_ovr;
            end else if (active_ff && sck_fall) begin
                tx_sh_ff <= {tx_sh_ff[6:0], 1'b0};
            end
        end
    end

    // Counts latched at end of granted transaction
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rx_count_ff <= '0;
            tx_count_ff <= '0;
        end else if (done) begin
            // RULE_04 receive count
            rx_count_ff <= rx_cnt_ff;
            // RULE_05 transmit count
            tx_count_ff <= tx_cnt_ff;
        end
    end

    // Read mux; unmapped and task addresses read zero
    always_comb begin
        nxt_rd_data = '0;
        unique case (addr)
            OFF_DONE_EV: nxt_rd_data[0] = ev_ff[EV_DONE];
            // RULE_02 receive full reads
            OFF_RXFULL_EV: nxt_rd_data[0] = ev_ff[EV_RXFULL];
            OFF_GRANT_EV: nxt_rd_data[0] = ev_ff[EV_GRANT];
            OFF_EVENT_TASK_SHORTCUTS: nxt_rd_data[0] = event_task_shortcuts_ff;
            OFF_IRQ_SET, OFF_IRQ_CLR: nxt_rd_data[NUM_EV-1:0] = inten_ff;
            OFF_OWNER: nxt_rd_data[1:0] = owner_ff;
            OFF_STATUS: nxt_rd_data[1:0] = st_ff;
            OFF_ENABLE: nxt_rd_data[0] = en_ff;
            OFF_PSEL_SCK: nxt_rd_data = psel_ff[0];
            OFF_PSEL_MISO: nxt_rd_data = psel_ff[1];
            OFF_PSEL_MOSI: nxt_rd_data = psel_ff[2];
            OFF_CHIP_SELECT_PIN_SELECT: nxt_rd_data = psel_ff[3];
            OFF_RX_PTR: nxt_rd_data = rx_ptr_ff;
            OFF_TX_PTR: nxt_rd_data = tx_ptr_ff;
            OFF_RX_LIMIT: nxt_rd_data[CNT_W-1:0] = rx_lim_ff;
            OFF_TX_LIMIT: nxt_rd_data[CNT_W-1:0] = tx_lim_ff;
            OFF_RX_COUNT: nxt_rd_data[CNT_W-1:0] = rx_count_ff;
            OFF_TX_COUNT: nxt_rd_data[CNT_W-1:0] = tx_count_ff;
            OFF_RX_LIST: nxt_rd_data[LIST_W-1:0] = rx_list_ff;
            OFF_TX_LIST: nxt_rd_data[LIST_W-1:0] = tx_list_ff;
            OFF_IGN_FILL: nxt_rd_data[7:0] = ign_fill_ff;
            OFF_OVR_FILL: nxt_rd_data[7:0] = ovr_fill_ff;
            OFF_BUF_IDX: nxt_rd_data[BUF_AW-1:0] = idx_ff;
            OFF_BUF_DATA: nxt_rd_data[7:0] = rx_mem[idx_ff];
            default: nxt_rd_data = '0;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rd_data_ff <= '0;
        end else begin
            rd_data_ff <= rd_en ? nxt_rd_data : '0;
        end
    end

    assign rd_data = rd_data_ff;
    assign miso_o = tx_sh_ff[7];
    assign miso_oe_n = oe_n_ff;
    assign irq = irq_ff;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_end;
        done ##1 ev_ff[EV_DONE];
    endsequence

    sequence s_busy_fall;
        cs_fall && owner_ff != SEM_FREE;
    endsequence

    property p_giveback;
        lock_give && owner_ff == SEM_CPU |=> owner_ff == SEM_FREE;
    endproperty
    a_giveback: assert property (p_giveback) else $error("give-back ignored"); // RULE_01

    property p_rxfull;
        rx_full |=> ev_ff[EV_RXFULL] [*2];
    endproperty
    a_rxfull: assert property (p_rxfull) else $error("rx full flag missing"); // RULE_02

    property p_ignfill;
        load && !nxt_grant |=> tx_sh_ff == $past(ign_fill_ff) && miso_o == tx_sh_ff[7];
    endproperty
    a_ignfill: assert property (p_ignfill) else $error("wrong ignored fill"); // RULE_03

    property p_counts;
        done |=> rx_count_ff == $past(rx_cnt_ff) && tx_count_ff == $past(tx_cnt_ff);
    endproperty
    a_counts: assert property (p_counts) else $error("counts not latched"); // RULE_04

    property p_rxlim;
        rx_over |=> rx_cnt_ff == $past(rx_cnt_ff) && st_ff[ST_OVERFLOW];
    endproperty
    a_rxlim: assert property (p_rxlim) else $error("overflow mishandled"); // RULE_13

    property p_txlim;
        load && nxt_ovr |=> tx_sh_ff == $past(ovr_fill_ff) && cur_ovr_ff;
    endproperty
    a_txlim: assert property (p_txlim) else $error("over-read mishandled"); // RULE_07

    property p_overread;
        byte_done && cur_ovr_ff |=> st_ff[ST_OVERREAD];
    endproperty
    a_overread: assert property (p_overread) else $error("over-read not flagged"); // RULE_08

    property p_txcount;
        byte_done && cur_take_ff |=> tx_cnt_ff == $past(tx_cnt_ff) + 1'b1;
    endproperty
    a_txcount: assert property (p_txcount) else $error("sent byte not counted"); // RULE_05

    property p_end;
        s_end |-> owner_ff != SEM_SPI && !active_ff;
    endproperty
    a_end: assert property (p_end) else $error("end did not free lock"); // RULE_10

    property p_short;
        done && event_task_shortcuts_ff |=> owner_ff == SEM_CPU && ev_ff[EV_GRANT];
    endproperty
    a_short: assert property (p_short) else $error("shortcut failed"); // RULE_09

    property p_ignore;
        s_busy_fall |=> active_ff && !granted_ff && !oe_n_ff;
    endproperty
    a_ignore: assert property (p_ignore) else $error("busy lock granted"); // RULE_11

    property p_lockreq;
        lock_req && owner_ff == SEM_CPU |=> ev_ff[EV_GRANT] && owner_ff == SEM_CPU;
    endproperty
    a_lockreq: assert property (p_lockreq) else $error("no immediate grant"); // RULE_12

    property p_clear;
        wr_at(OFF_DONE_EV) && !wr_data[0] && !done |=> !ev_ff[EV_DONE];
    endproperty
    a_clear: assert property (p_clear) else $error("flag not cleared"); // RULE_14
endmodule : sss_regs
